// ---- shared/cidaf_pkg.sv ----
/*
 constants for the identifier acceptance filter: register map,
 field positions, reset values, organization codes.
 assumes a 32-bit apb with byte addresses.
*/
// Behaviour
// - store message in background before deciding
// - signal cpu only for accepted messages; code also sets a drop event that raises irq when enabled
// - rejected message silently overwritten by next; code also sets the sticky drop event for it
// - compare code and identifier bytes per bit
// - extended identifier uses four bank bytes
// - standard identifier uses first two bytes
// - compare code bit, then qualify by mask
// - mask zero requires identifier equals code
// - accept only if all unmasked bits match
// - mask one means don't care
// - filter writes only in init mode
// - organization: 2x32, 4x16, 8x8, closed
// - closed mode accepts no message
// - hit indicator follows foreground load
`default_nettype none
package cidaf_pkg;
	// ---------------------------------------------
	// register byte addresses
	// ---------------------------------------------
	localparam logic [7:0] off_code_base = 8'h00; // 8 code words
	localparam logic [7:0] off_mask_base = 8'h20; // 8 mask words
	localparam logic [7:0] off_control = 8'h40; // organization, hit
	localparam logic [7:0] off_init = 8'h44; // init request/ack
	localparam logic [7:0] off_status = 8'h48; // sticky events
	localparam logic [7:0] off_clear = 8'h4C; // write one clears
	localparam logic [7:0] off_enable = 8'h50; // interrupt enable
	localparam logic [7:0] off_fg_id = 8'h54; // foreground ids
	// ---------------------------------------------
	// field positions and reset values
	// ---------------------------------------------
	localparam int org_lsb = 4; // organization field [5:4]
	localparam int hit_lsb = 0; // hit field [2:0]
	localparam int init_rq_bit = 0; // init request
	localparam int init_ak_bit = 1; // init acknowledge
	localparam int ev_accept = 0; // message accepted
	localparam int ev_drop = 1; // message dropped
	localparam int ide_bit = 3; // format bit in id byte 1
	localparam logic [7:0] code_reset = 8'h00;
	localparam logic [7:0] mask_reset = 8'h00;
	localparam logic [1:0] ev_reset = 2'h0;
	// ---------------------------------------------
	// organization codes
	// ---------------------------------------------
	localparam logic [1:0] org_two32 = 2'h0;
	localparam logic [1:0] org_four16 = 2'h1;
	localparam logic [1:0] org_eight8 = 2'h2;
	localparam logic [1:0] org_closed = 2'h3;
	// filter stage states, one-hot
	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_decide = 2'b10
	} cidaf_state_t;
endpackage
`default_nettype wire

// ---- rtl/cidaf_top.sv ----
/*
 identifier acceptance filter with apb register slave.
 assumes the receive engine on pclk pulses rx_valid with
 the four identifier bytes, and gives init_acknowledge.
*/
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cidaf_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_id0,
	input wire logic [7:0] rx_id1,
	input wire logic [7:0] rx_id2,
	input wire logic [7:0] rx_id3,
	input wire logic init_acknowledge,
	output logic init_request,
	output logic foreground_load,
	output logic [2:0] filter_hit_indicator,
	output logic irq
);
	import cidaf_pkg::*;

	// ---------------------------------------------
	// storage
	// ---------------------------------------------
	logic [7:0] acceptance_code_bytes [8]; // code bytes
	logic [7:0] acceptance_mask_bytes [8]; // mask bytes
	logic [1:0] acceptance_organization; // filter layout
	logic [7:0] bg_id [4]; // background buffer
	logic [7:0] foreground_receive_buffer [4]; // accepted ids
	logic [1:0] ev_status; // sticky events
	logic [1:0] ev_enable; // interrupt enables
	cidaf_state_t state; // filter stage
	logic [7:0] hits; // per-filter matches
	logic [7:0] m32; // byte j vs id byte j mod 4
	logic [7:0] m16; // byte j vs id byte j mod 2
	logic [7:0] m8; // byte j vs id byte 0
	logic [1:0] ev_set; // events this cycle
	logic wr_en; // write strobe of access phase
	logic setup; // setup phase
	logic init_mode; // filter writes allowed
	logic [31:0] next_prdata; // read mux
	logic next_pslverr; // unmapped address

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	// mask one is don't care, else bits must agree
	function automatic logic byte_match(input logic [7:0] code,
		input logic [7:0] mask, input logic [7:0] id);
		byte_match = &(~(code ^ id) | mask);
	endfunction

	// lowest set bit index
	function automatic logic [2:0] lowest(input logic [7:0] v);
		lowest = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				lowest = 3'(i);
			end
		end
	endfunction

	// whether an address is a word-aligned register of a block
	function automatic logic in_block(input logic [7:0] a,
		input logic [7:0] base);
		in_block = (a >= base) && (a < base + 8'h20) && (a[1:0] == 2'h0);
	endfunction

	// ---------------------------------------------
	// bus phases
	// ---------------------------------------------
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign init_mode = init_request & init_acknowledge;

	// ---------------------------------------------
	// per-byte comparisons
	// ---------------------------------------------
	genvar gj;
	generate
		for (gj = 0; gj < 8; gj++) begin : g_cmp
			assign m32[gj] = byte_match(acceptance_code_bytes[gj],
				acceptance_mask_bytes[gj], bg_id[gj % 4]);
			assign m16[gj] = byte_match(acceptance_code_bytes[gj],
				acceptance_mask_bytes[gj], bg_id[gj % 2]);
			assign m8[gj] = byte_match(acceptance_code_bytes[gj],
				acceptance_mask_bytes[gj], bg_id[0]);
		end
	endgenerate

	// ---------------------------------------------
	// filter hits per organization
	// ---------------------------------------------
	always_comb begin
		hits = 8'h00;
		case (acceptance_organization)
			org_two32: begin
				if (bg_id[1][ide_bit]) begin
					// extended: four bytes per bank
					hits[0] = &m32[3:0];
					hits[1] = &m32[7:4];
				end else begin
					// standard: first two bytes per bank
					hits[0] = &m32[1:0];
					hits[1] = &m32[5:4];
				end
			end
			org_four16: begin
				hits[0] = &m16[1:0];
				hits[1] = &m16[3:2];
				hits[2] = &m16[5:4];
				hits[3] = &m16[7:6];
			end
			org_eight8: begin
				hits = m8;
			end
			default: begin
				hits = 8'h00;
			end
		endcase
	end

	// ---------------------------------------------
	// background capture
	// ---------------------------------------------
	// each message lands here first, overwriting the last
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				bg_id[i] <= 8'h00;
			end
		end else if (rx_valid) begin
			bg_id[0] <= rx_id0;
			bg_id[1] <= rx_id1;
			bg_id[2] <= rx_id2;
			bg_id[3] <= rx_id3;
		end
	end

	// ---------------------------------------------
	// filter stage
	// ---------------------------------------------
	// decide one cycle after capture, on stored bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
		end else begin
			case (state)
				st_idle: begin
					if (rx_valid) begin
						state <= st_decide;
					end
				end
				st_decide: begin
					// a new capture keeps the stage busy
					state <= rx_valid ? st_decide : st_idle;
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// events raised by the decision
	always_comb begin
		ev_set = 2'h0;
		if (state == st_decide) begin
			ev_set[ev_accept] = |hits;
			ev_set[ev_drop] = ~|hits;
		end
	end

	// ---------------------------------------------
	// foreground load and hit indicator
	// ---------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				foreground_receive_buffer[i] <= 8'h00;
			end
			filter_hit_indicator <= 3'h0;
		end else if (ev_set[ev_accept]) begin
			for (int i = 0; i < 4; i++) begin
				foreground_receive_buffer[i] <= bg_id[i];
			end
			filter_hit_indicator <= lowest(hits);
		end
	end

	// one-cycle pulse per accepted message
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			foreground_load <= 1'b0;
		end else begin
			foreground_load <= ev_set[ev_accept];
		end
	end

	// ---------------------------------------------
	// filter registers
	// ---------------------------------------------
	// writes ignored outside init mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				acceptance_code_bytes[i] <= code_reset;
				acceptance_mask_bytes[i] <= mask_reset;
			end
		end else if (wr_en && init_mode) begin
			if (in_block(paddr, off_code_base)) begin
				acceptance_code_bytes[paddr[4:2]] <= pwdata[7:0];
			end
			if (in_block(paddr, off_mask_base)) begin
				acceptance_mask_bytes[paddr[4:2]] <= pwdata[7:0];
			end
		end
	end

	// organization field, init mode only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acceptance_organization <= org_two32;
		end else if (wr_en && init_mode && paddr == off_control) begin
			acceptance_organization <= pwdata[org_lsb +: 2];
		end
	end

	// init request bit, writable any time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_request <= 1'b0;
		end else if (wr_en && paddr == off_init) begin
			init_request <= pwdata[init_rq_bit];
		end
	end

	// ---------------------------------------------
	// events and interrupt
	// ---------------------------------------------
	// sticky status, a set beats a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_status <= ev_reset;
		end else if (wr_en && paddr == off_clear) begin
			ev_status <= (ev_status & ~pwdata[1:0]) | ev_set;
		end else begin
			ev_status <= ev_status | ev_set;
		end
	end

	// interrupt enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_enable <= ev_reset;
		end else if (wr_en && paddr == off_enable) begin
			ev_enable <= pwdata[1:0];
		end
	end

	// level interrupt while an enabled bit is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ev_status & ev_enable);
		end
	end

	// ---------------------------------------------
	// read mux
	// ---------------------------------------------
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (in_block(paddr, off_code_base)) begin
			next_prdata[7:0] = acceptance_code_bytes[paddr[4:2]];
		end else if (in_block(paddr, off_mask_base)) begin
			next_prdata[7:0] = acceptance_mask_bytes[paddr[4:2]];
		end else begin
			case (paddr)
				off_control: begin
					next_prdata[org_lsb +: 2] = acceptance_organization;
					next_prdata[hit_lsb +: 3] = filter_hit_indicator;
				end
				off_init: begin
					next_prdata[init_rq_bit] = init_request;
					next_prdata[init_ak_bit] = init_acknowledge;
				end
				off_status: begin
					next_prdata[1:0] = ev_status;
				end
				off_clear: begin
					next_prdata = 32'h0000_0000; // write only
				end
				off_enable: begin
					next_prdata[1:0] = ev_enable;
				end
				off_fg_id: begin
					next_prdata = {foreground_receive_buffer[3],
						foreground_receive_buffer[2],
						foreground_receive_buffer[1],
						foreground_receive_buffer[0]};
				end
				default: begin
					next_pslverr = 1'b1; // unmapped
				end
			endcase
		end
	end

	// ---------------------------------------------
	// apb answer, no wait state
	// ---------------------------------------------
	// sampled in setup, presented in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			prdata <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
			pslverr <= setup & next_pslverr;
		end
	end
endmodule
`default_nettype wire

// ---- test/cidaf_assertions.sv ----
/*
 checker: port-level timing of the acceptance filter.
 assumes it is bound onto cidaf_top, one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module cidaf_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_valid,
	input wire logic init_request,
	input wire logic foreground_load,
	input wire logic [2:0] filter_hit_indicator,
	input wire logic irq
);
	import cidaf_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// first step of a bus transfer
	sequence s_setup;
		psel && !penable;
	endsequence
	// completing write access
	sequence s_wr_acc;
		psel && penable && pwrite;
	endsequence
	chk_ready_next: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("prdata not zero outside read");
	chk_load_cause: assert property (foreground_load |-> $past(rx_valid, 2))
		else $error("load without message two cycles before");
	chk_hit_hold: assert property (!foreground_load |-> $stable(filter_hit_indicator))
		else $error("hit changed without load");
	// a write access that follows its own setup is answered at once
	chk_wr_ready: assert property (s_setup ##1 s_wr_acc |-> pready)
		else $error("write access without pready");
	chk_init_cause: assert property ($changed(init_request) |-> $past(psel && penable && pwrite && paddr == off_init))
		else $error("init request changed without write");
	// message: status one edge after decide, irq one edge later; enable write: irq one edge later
	chk_irq_cause: assert property ($rose(irq) |-> $past(rx_valid, 3) || $past(psel && penable && pwrite, 2))
		else $error("irq rose without cause");
endmodule
bind cidaf_top cidaf_assertions chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .rx_valid, .init_request, .foreground_load, .filter_hit_indicator, .irq);
`default_nettype wire

// ---- test/cidaf_rx_model.sv ----
/*
 receive engine model: sends identifier bytes, acknowledges init.
 assumes the bench calls send right after a clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module cidaf_rx_model (
	input wire logic pclk,
	input wire logic init_request,
	output logic rx_valid,
	output logic [7:0] rx_id0,
	output logic [7:0] rx_id1,
	output logic [7:0] rx_id2,
	output logic [7:0] rx_id3,
	output logic init_acknowledge
);
	logic ack_stage; // first stage of ack delay
	initial begin
		rx_valid = 1'b0;
		{rx_id0, rx_id1, rx_id2, rx_id3} = 32'h0;
		init_acknowledge = 1'b0;
		ack_stage = 1'b0;
	end
	// ack follows request two edges later, drops one edge after it
	always @(posedge pclk) begin
		ack_stage <= init_request;
		init_acknowledge <= ack_stage && init_request;
	end
	// one message; bytes inverted once no longer valid
	task automatic send(input logic [31:0] id);
		@(posedge pclk);
		rx_valid <= 1'b1;
		{rx_id0, rx_id1, rx_id2, rx_id3} <= id;
		@(posedge pclk);
		rx_valid <= 1'b0;
		{rx_id0, rx_id1, rx_id2, rx_id3} <= ~id;
	endtask
endmodule
`default_nettype wire

// ---- test/tb_can_identifier_acceptance_filter.sv ----
/*
 bench: apb register access, filter modes, events and interrupt.
 assumes cidaf_top, the receive model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_can_identifier_acceptance_filter;
	import cidaf_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid;
	logic init_acknowledge, init_request, foreground_load, irq, err;
	logic [7:0] paddr, rx_id0, rx_id1, rx_id2, rx_id3;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] filter_hit_indicator;
	int mismatches, compares;
	cidaf_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_valid, .rx_id0, .rx_id1, .rx_id2, .rx_id3, .init_acknowledge, .init_request, .foreground_load,
		.filter_hit_indicator, .irq);
	cidaf_rx_model rx_u (.pclk, .init_request, .rx_valid, .rx_id0, .rx_id1, .rx_id2, .rx_id3, .init_acknowledge);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// verdict and end of run
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// program all filter bytes and the organization
	task automatic filt(input logic [63:0] code, input logic [63:0] mask, input logic [1:0] org);
		for (int n = 0; n < 8; n++) begin
			apb(1'b1, off_code_base + 8'(4 * n), 32'(code[8 * (7 - n) +: 8]));
			apb(1'b1, off_mask_base + 8'(4 * n), 32'(mask[8 * (7 - n) +: 8]));
		end
		apb(1'b1, off_control, 32'(org) << org_lsb);
	endtask
	// one message, count load pulses and check hit
	task automatic msg(input logic [31:0] id, input logic exp_load, input logic [2:0] exp_hit);
		int loads;
		loads = 0;
		rx_u.send(id);
		repeat (4) begin
			@(posedge pclk);
			loads += int'(foreground_load === 1'b1);
		end
		cmp("load count", 32'(exp_load), 32'(loads));
		cmp("hit indicator", 32'(exp_hit), 32'(filter_hit_indicator));
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		mismatches = 0;
		compares = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int n = 0; n < 16; n++) begin
			apb(1'b0, 8'(4 * n), 32'h0);
			cmp("filter byte reset", 32'h0, rd);
		end
		apb(1'b0, 8'h60, 32'h0);
		cmp("unmapped error", 32'h1, 32'(err));
		apb(1'b1, off_code_base, 32'h5A);
		apb(1'b0, off_code_base, 32'h0);
		cmp("write outside init", 32'h0, rd);
		$display("test access done");
		apb(1'b1, off_enable, 32'h1);
		apb(1'b1, off_init, 32'h1);
		rd = 32'h0;
		for (int n = 0; n < 8 && rd[init_ak_bit] !== 1'b1; n++) apb(1'b0, off_init, 32'h0);
		cmp("init state", 32'h3, rd);
		filt(64'h1120_0000_AABB_CCDD, 64'h0007_0000_0000_0001, org_two32);
		apb(1'b0, off_code_base + 8'h04, 32'h0);
		cmp("write in init", 32'h20, rd);
		msg(32'hAABB_CCDD, 1'b1, 3'h1);
		msg(32'h1125_9966, 1'b1, 3'h0);
		msg(32'hAABB_CCDC, 1'b1, 3'h1);
		msg(32'hAABB_CDDD, 1'b0, 3'h1);
		apb(1'b0, off_fg_id, 32'h0);
		cmp("foreground id", 32'hDCCC_BBAA, rd);
		cmp("irq raised", 32'h1, 32'(irq));
		apb(1'b0, off_status, 32'h0);
		cmp("status", 32'h3, rd);
		apb(1'b1, off_clear, 32'h3);
		apb(1'b0, off_status, 32'h0);
		cmp("status cleared", 32'h0, rd);
		cmp("irq cleared", 32'h0, 32'(irq));
		$display("test wide filters done");
		apb(1'b1, off_enable, 32'h2);
		filt(64'h0102_0304_5566_5500, 64'h0000_0000_0000_00FF, org_four16);
		msg(32'h5566_7788, 1'b1, 3'h2);
		cmp("irq masked", 32'h0, 32'(irq));
		apb(1'b1, off_control, 32'(org_eight8) << org_lsb);
		msg(32'h6601_0203, 1'b1, 3'h5);
		msg(32'h7700_0000, 1'b1, 3'h7);
		apb(1'b1, off_control, 32'(org_closed) << org_lsb);
		msg(32'h6600_0000, 1'b0, 3'h7);
		$display("test narrow filters done");
		stop_test();
	end
endmodule
`default_nettype wire
